// ===== fifo_host_pkg.sv
// Shared constants and state encodings for the pin-level FIFO host controller.
package fifo_host_pkg;

  // ==========================================================================
  // Clock and device geometry
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEV_WIDTH     = 5;
  localparam int DEV_DEPTH     = 64;
  localparam int BUF_DEPTH     = 32;

  // ==========================================================================
  // Device timing, in the units printed
  // ==========================================================================
  localparam int T_CLEAR_NS         = 40;
  localparam int T_CLEAR_TO_PUSH_NS = 35;
  localparam int F_STROBE_MAX_MHZ   = 5;
  localparam int T_STROBE_PERIOD_NS = 1000 / F_STROBE_MAX_MHZ;
  localparam int T_FALL_THROUGH_US  = 4;

  // Least times round up to whole cycles, never below one.
  function automatic int cycles_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CLEAR_CYC       = cycles_min(T_CLEAR_NS);
  localparam int CLEAR_GAP_CYC   = cycles_min(T_CLEAR_TO_PUSH_NS);
  localparam int STROBE_CYC      = cycles_min(T_STROBE_PERIOD_NS);
  localparam int STROBE_HALF_CYC = STROBE_CYC / 2;
  localparam int FALL_CYC        = cycles_min(T_FALL_THROUGH_US * 1000);

  localparam int CNT_W = 9;
  typedef logic [CNT_W-1:0] cnt_t;

  // ==========================================================================
  // State encodings
  // ==========================================================================
  typedef enum logic [5:0] {
    W_CLR   = 6'h01,
    W_GAP   = 6'h02,
    W_IDLE  = 6'h04,
    W_SETUP = 6'h08,
    W_HIGH  = 6'h10,
    W_LOW   = 6'h20
  } write_state_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'h1,
    R_HIGH = 3'h2,
    R_LOW  = 3'h4
  } read_state_t;

endpackage

// ===== fifo_stream_if.sv
// Valid/ready word stream between the host and its staging buffer.
`timescale 1ns/1ns
interface fifo_stream_if #(parameter int W = 5);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== stream_fifo.sv
// Flip-flop FIFO with parameterised width and depth, valid and ready on both sides.
`timescale 1ns/1ns
module stream_fifo
  import fifo_host_pkg::*;
#(
  parameter int W     = DEV_WIDTH,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic    clock,
  input wire logic    rst_n,
  fifo_stream_if.snk  wr,
  fifo_stream_if.src  rd
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        do_wr;
  logic        do_rd;

  // Wraps explicitly so a depth that is not a power of two still works.
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign wr.ready = (st_r.cnt != CW'(DEPTH));
  assign rd.valid = (st_r.cnt != '0);
  assign rd.data  = st_r.mem[st_r.rp];
  assign do_wr    = wr.valid && wr.ready;
  assign do_rd    = rd.valid && rd.ready;

  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.mem[st_r.wp] = wr.data;
      st_nxt.wp           = next_ptr(st_r.wp);
    end
    if (do_rd) begin
      st_nxt.rp = next_ptr(st_r.rp);
    end
    if (do_wr && !do_rd) begin
      st_nxt.cnt = CW'(st_r.cnt + 1'b1);
    end else if (do_rd && !do_wr) begin
      st_nxt.cnt = CW'(st_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // stream_fifo

// ===== fifo_pin_host.sv
// Host controller driving one or more side-by-side fall-through FIFO devices by their pins.
`timescale 1ns/1ns
module fifo_pin_host
  import fifo_host_pkg::*;
#(
  parameter int N_DEV = 1,
  parameter int DEPTH = BUF_DEPTH,
  parameter int W     = DEV_WIDTH * N_DEV
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [W-1:0]     in_data,
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [W-1:0]     out_data,
  output wire logic             dev_full,
  output wire logic             dev_empty,
  output wire logic [W-1:0]     dev_din,
  output wire logic             dev_push,
  output wire logic             dev_pop,
  output wire logic             clear_n,
  input  wire logic [N_DEV-1:0] space_avail,
  input  wire logic [N_DEV-1:0] word_valid,
  input  wire logic [W-1:0]     dev_dout
);

  typedef struct packed {
    write_state_t     ws;
    read_state_t      rs;
    cnt_t             wcnt;
    cnt_t             rcnt;
    logic             clear_n;
    logic             push;
    logic             pop;
    logic [W-1:0]     din;
    logic             ov;
    logic [W-1:0]     od;
    logic [N_DEV-1:0] sa_m;
    logic [N_DEV-1:0] sa_s;
    logic [N_DEV-1:0] wv_m;
    logic [N_DEV-1:0] wv_s;
    logic [W-1:0]     do_m;
    logic [W-1:0]     do_s;
    cnt_t             sa_lo;
    cnt_t             wv_lo;
    logic             full;
    logic             empty;
  } host_state_t;

  // Clear is low out of reset, so the device is cleared before any strobe.
  localparam host_state_t ST_RST = '{ws: W_CLR, rs: R_IDLE, default: '0};

  host_state_t st_r;
  host_state_t st_nxt;
  logic        take;
  logic        sa_all;
  logic        wv_all;
  logic        clear_done;

  fifo_stream_if #(.W(W)) wr_if ();
  fifo_stream_if #(.W(W)) rd_if ();

  stream_fifo #(.W(W), .DEPTH(DEPTH)) u_buf (
    .clock (clock),
    .rst_n (rst_n),
    .wr    (wr_if),
    .rd    (rd_if)
  );

  function automatic cnt_t bump(input cnt_t c);
    return cnt_t'(c + 1'b1);
  endfunction

  // ==========================================================================
  // Pin-facing outputs and composite flags
  // ==========================================================================
  assign wr_if.valid = in_valid;
  assign wr_if.data  = in_data;
  assign in_ready    = wr_if.ready;
  assign rd_if.ready = take;
  assign out_valid   = st_r.ov;
  assign out_data    = st_r.od;
  assign dev_full    = st_r.full;
  assign dev_empty   = st_r.empty;
  assign dev_din     = st_r.din;
  assign dev_push    = st_r.push;
  assign dev_pop     = st_r.pop;
  assign clear_n     = st_r.clear_n;
  assign sa_all      = &st_r.sa_s;
  assign wv_all      = &st_r.wv_s;
  assign clear_done  = (st_r.ws != W_CLR) && (st_r.ws != W_GAP);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    st_nxt      = st_r;
    take        = 1'b0;
    st_nxt.sa_m = space_avail;
    st_nxt.sa_s = st_r.sa_m;
    st_nxt.wv_m = word_valid;
    st_nxt.wv_s = st_r.wv_m;
    st_nxt.do_m = dev_dout;
    st_nxt.do_s = st_r.do_m;

    // Flags are only trusted as full or empty after a whole fall-through time.
    st_nxt.sa_lo = sa_all ? '0 : ((st_r.sa_lo == cnt_t'(FALL_CYC)) ? st_r.sa_lo : bump(st_r.sa_lo));
    st_nxt.wv_lo = wv_all ? '0 : ((st_r.wv_lo == cnt_t'(FALL_CYC)) ? st_r.wv_lo : bump(st_r.wv_lo));
    st_nxt.full  = !sa_all && (st_r.sa_lo == cnt_t'(FALL_CYC));
    st_nxt.empty = !wv_all && (st_r.wv_lo == cnt_t'(FALL_CYC));

    case (st_r.ws)
      W_CLR: begin
        st_nxt.clear_n = 1'b0;
        if (st_r.wcnt == cnt_t'(CLEAR_CYC - 1)) begin
          st_nxt.clear_n = 1'b1;
          st_nxt.wcnt    = '0;
          st_nxt.ws      = W_GAP;
        end else begin
          st_nxt.wcnt = bump(st_r.wcnt);
        end
      end
      W_GAP: begin
        if (st_r.wcnt == cnt_t'(CLEAR_GAP_CYC - 1)) begin
          st_nxt.wcnt = '0;
          st_nxt.ws   = W_IDLE;
        end else begin
          st_nxt.wcnt = bump(st_r.wcnt);
        end
      end
      W_IDLE: begin
        // A push while the composite flag is low would be ignored, so none is made.
        if (rd_if.valid && sa_all) begin
          take       = 1'b1;
          st_nxt.din = rd_if.data;
          st_nxt.ws  = W_SETUP;
        end
      end
      W_SETUP: begin
        st_nxt.push = 1'b1;
        st_nxt.wcnt = '0;
        st_nxt.ws   = W_HIGH;
      end
      W_HIGH: begin
        if (st_r.wcnt == cnt_t'(STROBE_HALF_CYC - 1)) begin
          st_nxt.push = 1'b0;
          st_nxt.wcnt = '0;
          st_nxt.ws   = W_LOW;
        end else begin
          st_nxt.wcnt = bump(st_r.wcnt);
        end
      end
      W_LOW: begin
        if (st_r.wcnt == cnt_t'(STROBE_HALF_CYC - 1)) begin
          st_nxt.wcnt = '0;
          st_nxt.ws   = W_IDLE;
        end else begin
          st_nxt.wcnt = bump(st_r.wcnt);
        end
      end
      default: begin
        st_nxt.ws = W_CLR;
      end
    endcase

    if (out_ready && st_r.ov) begin
      st_nxt.ov = 1'b0;
    end

    case (st_r.rs)
      R_IDLE: begin
        // The word is taken on the same edge that raises the pop, while the device still holds it stable.
        if (clear_done && wv_all && !st_r.ov) begin
          st_nxt.ov   = 1'b1;
          st_nxt.od   = st_r.do_s;
          st_nxt.pop  = 1'b1;
          st_nxt.rcnt = '0;
          st_nxt.rs   = R_HIGH;
        end
      end
      R_HIGH: begin
        if (st_r.rcnt == cnt_t'(STROBE_HALF_CYC - 1)) begin
          st_nxt.pop  = 1'b0;
          st_nxt.rcnt = '0;
          st_nxt.rs   = R_LOW;
        end else begin
          st_nxt.rcnt = bump(st_r.rcnt);
        end
      end
      R_LOW: begin
        // The low phase also covers flag settling plus the two-stage synchroniser.
        if (st_r.rcnt == cnt_t'(STROBE_HALF_CYC - 1)) begin
          st_nxt.rcnt = '0;
          st_nxt.rs   = R_IDLE;
        end else begin
          st_nxt.rcnt = bump(st_r.rcnt);
        end
      end
      default: begin
        st_nxt.rs = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  cnt_t push_gap;
  cnt_t pop_gap;
  logic push_q;
  logic pop_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      push_gap <= '1;
      pop_gap  <= '1;
      push_q   <= 1'b0;
      pop_q    <= 1'b0;
    end else begin
      push_q   <= dev_push;
      pop_q    <= dev_pop;
      push_gap <= (dev_push && !push_q) ? cnt_t'(1) : ((push_gap == '1) ? push_gap : bump(push_gap));
      pop_gap  <= (dev_pop && !pop_q) ? cnt_t'(1) : ((pop_gap == '1) ? pop_gap : bump(pop_gap));
    end
  end

  sequence s_push_high;
    dev_push [*8];
  endsequence

  sequence s_push_low;
    !dev_push [*8];
  endsequence

  property p_clear_pulse;
    @(posedge clock) disable iff (!rst_n)
    $rose(clear_n) |-> !$past(clear_n, 1) && !$past(clear_n, 4);
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too short");

  property p_no_push_in_clear;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_push) |-> clear_n && $past(clear_n, 4);
  endproperty
  a_no_push_in_clear: assert property (p_no_push_in_clear) else $error("push during clear");

  property p_pop_needs_valid;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_pop) |-> $past(wv_all) && out_valid;
  endproperty
  a_pop_needs_valid: assert property (p_pop_needs_valid) else $error("pop without valid");

  property p_pop_held;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_pop) |-> dev_pop [*8] ##[1:4] !dev_pop;
  endproperty
  a_pop_held: assert property (p_pop_held) else $error("pop strobe shape wrong");

  property p_push_shape;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_push) |-> s_push_high ##[1:4] !dev_push ##1 s_push_low;
  endproperty
  a_push_shape: assert property (p_push_shape) else $error("push strobe shape wrong");

  property p_push_rate;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_push) |-> push_gap >= cnt_t'(STROBE_CYC);
  endproperty
  a_push_rate: assert property (p_push_rate) else $error("push rate too high");

  property p_pop_rate;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_pop) |-> pop_gap >= cnt_t'(STROBE_CYC);
  endproperty
  a_pop_rate: assert property (p_pop_rate) else $error("pop rate too high");

  property p_push_needs_space;
    @(posedge clock) disable iff (!rst_n)
    $rose(dev_push) |-> $past(sa_all, 2) && $stable(dev_din);
  endproperty
  a_push_needs_space: assert property (p_push_needs_space) else $error("push without space");

  property p_full_drop;
    @(posedge clock) disable iff (!rst_n)
    sa_all |=> !dev_full;
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full while space seen");

  property p_empty_drop;
    @(posedge clock) disable iff (!rst_n)
    wv_all |=> !dev_empty;
  endproperty
  a_empty_drop: assert property (p_empty_drop) else $error("empty while valid seen");

endmodule // fifo_pin_host

// ===== fall_through_dev.sv
// Behavioural model of one fall-through FIFO device seen at its pins.
`timescale 1ns/1ns
module fall_through_dev
  import fifo_host_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 clear_n,
  input  wire logic                 push,
  input  wire logic                 pop,
  input  wire logic [DEV_WIDTH-1:0] din,
  input  wire logic [8:0]           lat,
  output logic                      space_avail,
  output logic                      word_valid,
  output logic [DEV_WIDTH-1:0]      dout,
  output int                        bad_cnt
);
  logic [DEV_WIDTH-1:0] q[$];
  logic                 held_r;
  logic                 pop_r;
  logic                 push_q;
  logic                 pop_q;
  int                   wait_r;

  initial begin
    space_avail = 1'b0;
    word_valid  = 1'b0;
    dout        = 5'h0a;
    bad_cnt     = 0;
  end

  // ==========================================================================
  // Device behaviour
  // ==========================================================================
  // Updating on the falling edge keeps the host's synchronisers clear of races.
  always @(negedge clock) begin
    if (clear_n !== 1'b1) begin
      q.delete();
      held_r      = 1'b0;
      pop_r       = 1'b0;
      wait_r      = 0;
      word_valid  = 1'b0;
      space_avail = 1'b1;
    end else begin
      if (push && !push_q && !space_avail) bad_cnt++;
      if (pop && !pop_q && !word_valid) bad_cnt++;
      if (push && space_avail && !held_r) begin
        q.push_back(din);
        held_r      = 1'b1;
        space_avail = 1'b0;
      end
      if (!push) held_r = 1'b0;
      if (!held_r && !space_avail && (q.size() + (word_valid | pop_r)) < DEV_DEPTH)
        space_avail = 1'b1;
      if (pop && word_valid) begin
        word_valid = 1'b0;
        pop_r      = 1'b1;
      end else if (!pop && pop_r) begin
        pop_r  = 1'b0;
        wait_r = 0;
      end
      if (!word_valid && !pop_r && q.size() > 0) begin
        if (wait_r >= lat) begin
          dout       = q.pop_front();
          word_valid = 1'b1;
          wait_r     = 0;
        end else begin
          wait_r++;
        end
      end
    end
    push_q = push;
    pop_q  = pop;
  end
endmodule // fall_through_dev

// ===== testbench.sv
// Self-checking testbench for the pin-level FIFO host with a device model.
`timescale 1ns/1ns
module testbench;
  import fifo_host_pkg::*;
  logic        clock;
  logic        rst_n;
  logic        in_valid;
  logic        out_ready;
  logic [9:0]  in_data;
  logic [8:0]  lat;
  wire logic [8:0] lat_hi;
  logic        a_done;
  logic [31:0] seed = 32'h52f4_225f;
  logic [9:0]  exp_q[$];
  wire logic   in_ready, out_valid, dev_full, dev_empty, dev_push, dev_pop, clear_n;
  wire logic [1:0] space_avail, word_valid;
  wire logic [9:0] out_data, dev_din, dev_dout;
  int          bad_cnt, bad_cnt_hi, miscompares, checks, n_seen, n;

  // Two devices side by side with unequal fall-through, so the composite flags really matter.
  assign lat_hi = {1'b0, lat[8:1]};

  fifo_pin_host #(.N_DEV(2)) DUT (.clock(clock), .rst_n(rst_n), .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .dev_full(dev_full), .dev_empty(dev_empty), .dev_din(dev_din), .dev_push(dev_push),
    .dev_pop(dev_pop), .clear_n(clear_n), .space_avail(space_avail),
    .word_valid(word_valid), .dev_dout(dev_dout));

  fall_through_dev dev (.clock(clock), .clear_n(clear_n), .push(dev_push), .pop(dev_pop),
    .din(dev_din[4:0]), .lat(lat), .space_avail(space_avail[0]), .word_valid(word_valid[0]),
    .dout(dev_dout[4:0]), .bad_cnt(bad_cnt));

  fall_through_dev dev_hi (.clock(clock), .clear_n(clear_n), .push(dev_push), .pop(dev_pop),
    .din(dev_din[9:5]), .lat(lat_hi), .space_avail(space_avail[1]),
    .word_valid(word_valid[1]), .dout(dev_dout[9:5]), .bad_cnt(bad_cnt_hi));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Notes the word only once the edge that takes it has passed.
  task automatic send(input logic [9:0] d);
    int k;
    @(negedge clock);
    in_valid = 1'b1;
    in_data  = d;
    k = 0;
    while (in_ready !== 1'b1 && k < 5000) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
    exp_q.push_back(d);
  endtask

  always @(posedge clock) begin
    if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(out_data, exp_q.pop_front());
      n_seen++;
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    summarize();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_data = 5'h00;
    out_ready = 1'b0;
    lat = 9'd300;
    a_done = 1'b0;
    repeat (10) @(negedge clock);
    check({clear_n, dev_push, dev_pop, out_valid, in_ready, dev_full, dev_empty}, 7'h04);
    rst_n = 1'b1;
    n = 0;
    while (clear_n !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check(n >= CLEAR_CYC, 1);
    $display("test reset finished");

    repeat (420) @(negedge clock);
    check(dev_empty, 1'b1);
    out_ready = 1'b1;
    send(10'h2b5);
    @(negedge clock);
    in_valid = 1'b0;
    n = 0;
    while (out_valid !== 1'b1 && n < FALL_CYC + 60) begin
      @(negedge clock);
      n++;
    end
    check(n < FALL_CYC + 60, 1);
    check(dev_empty, 1'b0);
    // The word must be taken before back-pressure starts, or the fill below overflows by one.
    @(negedge clock);
    check(n_seen, 1);
    $display("test fall through finished");

    lat = 9'd2;
    out_ready = 1'b0;
    repeat (DEV_DEPTH + BUF_DEPTH + 1) send(10'(rnd()));
    @(negedge clock);
    in_valid = 1'b0;
    repeat (500) @(negedge clock);
    check(in_ready, 1'b0);
    check(dev_full, 1'b1);
    check(space_avail, 2'h0);
    $display("test fill finished");

    lat = 9'd40;
    fork
      begin
        repeat (60) send(10'(rnd()));
        @(negedge clock);
        in_valid = 1'b0;
        a_done = 1'b1;
      end
      begin
        n = 0;
        while ((!a_done || exp_q.size() > 0) && n < 40000) begin
          @(negedge clock);
          out_ready = 1'(rnd());
          n++;
        end
      end
    join
    repeat (420) @(negedge clock);
    check(n_seen, 1 + DEV_DEPTH + BUF_DEPTH + 1 + 60);
    check(bad_cnt, 0);
    check(bad_cnt_hi, 0);
    check({dev_full, dev_empty}, 2'h1);
    $display("test drain finished");
    summarize();
  end
endmodule // testbench
